// >>> rtl/flash_host_pkg.sv
// Constants and types shared by the flash bus host controller.
// Assumes a single 100 MHz system clock; all pin timing is counted in it.
package flash_host_pkg;

    // ------------------------------------------------------------------
    // Bus widths and clock
    // ------------------------------------------------------------------
    localparam int ADDR_W        = 20;
    localparam int DATA_W        = 16;
    localparam int CNT_W         = 16;
    localparam int CLK_PERIOD_NS = 10;

    // ------------------------------------------------------------------
    // Pin timing, in ns as chosen, and derived cycle counts (rounded up)
    // ------------------------------------------------------------------
    localparam int T_SETUP_NS    = 20;   // Address/data set before strobe
    localparam int T_PULSE_NS    = 50;   // Write strobe low time
    localparam int T_ACCESS_NS   = 70;   // Output drive low before sampling
    localparam int T_RECOVER_NS  = 30;   // Bus idle between cycles
    localparam int T_RESET_NS    = 100;  // Hard reset low time
    localparam int T_WAKE_NS     = 150;  // Quiet time after reset release

    localparam logic [CNT_W-1:0] SETUP_CYC   =
        CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PULSE_CYC   =
        CNT_W'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACCESS_CYC  =
        CNT_W'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RECOVER_CYC =
        CNT_W'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RESET_CYC   =
        CNT_W'((T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WAKE_CYC    =
        CNT_W'((T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ONE_CYC     = 16'h0001;

    // ------------------------------------------------------------------
    // Command codes and status bits
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] CMD_READ_ARRAY    = 16'h00ff;
    localparam logic [DATA_W-1:0] CMD_ERASE_CONFIRM = 16'h00d0;
    localparam int SR_PROG_ERR_BIT  = 4;
    localparam int SR_ERASE_ERR_BIT = 5;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ       = 3'h0,  // Plain bus read in the current read mode
        OP_ARRAY_CMD  = 3'h1,
        OP_STATUS_CMD = 3'h2,
        OP_SIG_CMD    = 3'h3,
        OP_CFI_CMD    = 3'h4,
        OP_ERASE      = 3'h5,
        OP_PROGRAM    = 3'h6,
        OP_RESET      = 3'h7
    } op_type;

    typedef enum logic [3:0] {
        MD_ARRAY  = 4'h1,
        MD_STATUS = 4'h2,
        MD_SIG    = 4'h4,
        MD_CFI    = 4'h8
    } mode_type;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_SETUP   = 7'h02,
        ST_STROBE  = 7'h04,
        ST_RELEASE = 7'h08,
        ST_GAP     = 7'h10,
        ST_RESET   = 7'h20,
        ST_WAKE    = 7'h40
    } state_type;

    typedef struct packed {
        op_type              op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } req_type;

endpackage : flash_host_pkg

// >>> rtl/delay_counter.sv
// Down counter that times one phase of a bus cycle.
// Assumes the caller loads it once per phase and waits for o_expired.
`timescale 1ns/1ps
module delay_counter
    import flash_host_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_load,
    input  wire logic [CNT_W-1:0] i_count,
    output logic                  o_expired
);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             expired_ff;
    logic             nxt_expired;

    // Load restarts; expiry is registered so the phase lasts count+1 cycles
    always_comb begin
        nxt_cnt     = cnt_ff;
        nxt_expired = 1'b0;
        if (i_load) begin
            nxt_cnt = i_count;
        end else begin
            if (cnt_ff != '0) begin
                nxt_cnt = cnt_ff - 1'b1;
            end
            nxt_expired = (cnt_ff <= ONE_CYC);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff     <= '0;
            expired_ff <= 1'b0;
        end else begin
            cnt_ff     <= nxt_cnt;
            expired_ff <= nxt_expired;
        end
    end

    assign o_expired = expired_ff;

endmodule : delay_counter

// >>> rtl/flash_bus_host.sv
// Host controller driving a 16-bit parallel NOR flash over its pins.
// Assumes flash pins are synchronous to i_clk_sys and the data wire is
// resolved outside from o_data_lines_out / o_data_lines_oe.
`timescale 1ns/1ps
module flash_bus_host
    import flash_host_pkg::*;
#(
    parameter logic [DATA_W-1:0] CMD_STATUS  = 16'h0070,
    parameter logic [DATA_W-1:0] CMD_SIG     = 16'h0090,
    parameter logic [DATA_W-1:0] CMD_CFI     = 16'h0098,
    parameter logic [DATA_W-1:0] CMD_ERASE   = 16'h0020,
    parameter logic [DATA_W-1:0] CMD_PROGRAM = 16'h0040,
    parameter int                READY_BIT   = 7,
    parameter int                POLL_LIMIT  = 100000
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic              i_req_valid,
    input  wire req_type           i_req,
    output logic                   o_busy,
    output logic                   o_done,
    output logic                   o_error,
    output logic [DATA_W-1:0]      o_rdata,
    output mode_type               o_mode,
    output logic                   o_ce_n,
    output logic                   o_oe_n,
    output logic                   o_we_n,
    output logic                   o_hard_reset_n,
    output logic [ADDR_W-1:0]      o_address_lines,
    output logic [DATA_W-1:0]      o_data_lines_out,
    output logic                   o_data_lines_oe,
    input  wire logic [DATA_W-1:0] i_data_lines_in
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Data of write step 0 or 1 of an operation
    function automatic logic [DATA_W-1:0] cycle_data(input op_type op,
            input logic step, input logic [DATA_W-1:0] d);
        case (op)
            OP_ARRAY_CMD:  cycle_data = CMD_READ_ARRAY;
            OP_STATUS_CMD: cycle_data = CMD_STATUS;
            OP_SIG_CMD:    cycle_data = CMD_SIG;
            OP_CFI_CMD:    cycle_data = CMD_CFI;
            OP_ERASE:      cycle_data = step ? CMD_ERASE_CONFIRM : CMD_ERASE;
            OP_PROGRAM:    cycle_data = step ? d : CMD_PROGRAM;
            default:       cycle_data = '0;
        endcase
    endfunction : cycle_data

    function automatic logic two_step(input op_type op);
        two_step = (op == OP_ERASE) || (op == OP_PROGRAM);
    endfunction : two_step

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    state_type         state_ff, nxt_state;
    req_type           req_ff, nxt_req;
    mode_type          mode_ff, nxt_mode;
    logic              ce_n_ff, nxt_ce_n, oe_n_ff, nxt_oe_n, we_n_ff, nxt_we_n;
    logic              rst_n_ff, nxt_rst_n, doe_ff, nxt_doe;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] dout_ff, nxt_dout, rdata_ff, nxt_rdata;
    logic              rd_ff, nxt_rd, step_ff, nxt_step, poll_ff, nxt_poll;
    logic [19:0]       pcnt_ff, nxt_pcnt;
    logic              busy_ff, nxt_busy, done_ff, nxt_done, err_ff, nxt_err;
    logic              ld;
    logic [CNT_W-1:0]  ldv;
    logic              expired;

    delay_counter u_timer (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_load    (ld),
        .i_count   (ldv),
        .o_expired (expired)
    );

    // ------------------------------------------------------------------
    // Sequencer: next values
    // ------------------------------------------------------------------
    // Each bus cycle is SETUP -> STROBE -> RELEASE -> GAP
    always_comb begin
        nxt_state = state_ff;  nxt_req  = req_ff;   nxt_mode  = mode_ff;
        nxt_ce_n  = ce_n_ff;   nxt_oe_n = oe_n_ff;  nxt_we_n  = we_n_ff;
        nxt_rst_n = rst_n_ff;  nxt_doe  = doe_ff;   nxt_addr  = addr_ff;
        nxt_dout  = dout_ff;   nxt_rdata = rdata_ff; nxt_rd   = rd_ff;
        nxt_step  = step_ff;   nxt_poll = poll_ff;  nxt_pcnt  = pcnt_ff;
        nxt_busy  = busy_ff;   nxt_err  = err_ff;   nxt_done  = 1'b0;
        ld        = 1'b0;      ldv      = ONE_CYC;
        case (state_ff)
            ST_IDLE: if (i_req_valid) begin
                nxt_req  = i_req;
                nxt_busy = 1'b1;
                nxt_step = 1'b0;
                nxt_poll = 1'b0;
                nxt_pcnt = '0;
                nxt_err  = 1'b0;
                ld       = 1'b1;
                if (i_req.op == OP_RESET) begin
                    nxt_rst_n = 1'b0;
                    ldv       = RESET_CYC;
                    nxt_state = ST_RESET;
                end else begin
                    nxt_rd    = (i_req.op == OP_READ);
                    nxt_ce_n  = 1'b0;
                    nxt_addr  = i_req.addr;
                    nxt_dout  = cycle_data(i_req.op, 1'b0, i_req.data);
                    nxt_doe   = (i_req.op != OP_READ);
                    ldv       = SETUP_CYC;
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: if (expired) begin
                ld = 1'b1;
                if (rd_ff) begin
                    nxt_oe_n = 1'b0;
                    ldv      = ACCESS_CYC;
                end else begin
                    nxt_we_n = 1'b0;
                    ldv      = PULSE_CYC;
                end
                nxt_state = ST_STROBE;
            end
            ST_STROBE: if (expired) begin
                if (rd_ff) begin
                    nxt_rdata = i_data_lines_in;
                    nxt_oe_n  = 1'b1;
                end else begin
                    nxt_we_n  = 1'b1;
                end
                ld        = 1'b1;
                nxt_state = ST_RELEASE;
            end
            ST_RELEASE: if (expired) begin
                nxt_ce_n  = 1'b1;
                nxt_doe   = 1'b0;
                ld        = 1'b1;
                ldv       = RECOVER_CYC;
                nxt_state = ST_GAP;
            end
            ST_GAP: if (expired) begin
                if (poll_ff && rdata_ff[READY_BIT]) begin
                    nxt_mode  = MD_STATUS;
                    nxt_err   = rdata_ff[SR_ERASE_ERR_BIT] |
                                rdata_ff[SR_PROG_ERR_BIT];
                    nxt_busy  = 1'b0;
                    nxt_done  = 1'b1;
                    nxt_state = ST_IDLE;
                end else if (poll_ff && pcnt_ff == 20'(POLL_LIMIT - 1)) begin
                    nxt_err   = 1'b1;
                    nxt_rst_n = 1'b0;
                    ld        = 1'b1;
                    ldv       = RESET_CYC;
                    nxt_state = ST_RESET;
                end else if (poll_ff || (two_step(req_ff.op) && step_ff)) begin
                    nxt_poll  = 1'b1;
                    nxt_pcnt  = poll_ff ? pcnt_ff + 20'h00001 : '0;
                    nxt_rd    = 1'b1;
                    nxt_ce_n  = 1'b0;
                    ld        = 1'b1;
                    ldv       = SETUP_CYC;
                    nxt_state = ST_SETUP;
                end else if (two_step(req_ff.op)) begin
                    nxt_step  = 1'b1;
                    nxt_dout  = cycle_data(req_ff.op, 1'b1, req_ff.data);
                    nxt_doe   = 1'b1;
                    nxt_ce_n  = 1'b0;
                    ld        = 1'b1;
                    ldv       = SETUP_CYC;
                    nxt_state = ST_SETUP;
                end else begin
                    case (req_ff.op)
                        OP_ARRAY_CMD:  nxt_mode = MD_ARRAY;
                        OP_STATUS_CMD: nxt_mode = MD_STATUS;
                        OP_SIG_CMD:    nxt_mode = MD_SIG;
                        OP_CFI_CMD:    nxt_mode = MD_CFI;
                        default:       nxt_mode = mode_ff;
                    endcase
                    nxt_busy  = 1'b0;
                    nxt_done  = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_RESET: if (expired) begin
                nxt_rst_n = 1'b1;
                ld        = 1'b1;
                ldv       = WAKE_CYC;
                nxt_state = ST_WAKE;
            end
            ST_WAKE: if (expired) begin
                nxt_mode  = MD_ARRAY;
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
                nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer: registers (pins idle high, reset pin released)
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;  req_ff  <= '0;       mode_ff  <= MD_ARRAY;
            ce_n_ff  <= 1'b1;     oe_n_ff <= 1'b1;     we_n_ff  <= 1'b1;
            rst_n_ff <= 1'b1;     doe_ff  <= 1'b0;     addr_ff  <= '0;
            dout_ff  <= '0;       rdata_ff <= '0;      rd_ff    <= 1'b0;
            step_ff  <= 1'b0;     poll_ff <= 1'b0;     pcnt_ff  <= '0;
            busy_ff  <= 1'b0;     done_ff <= 1'b0;     err_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state; req_ff  <= nxt_req;  mode_ff  <= nxt_mode;
            ce_n_ff  <= nxt_ce_n;  oe_n_ff <= nxt_oe_n; we_n_ff  <= nxt_we_n;
            rst_n_ff <= nxt_rst_n; doe_ff  <= nxt_doe;  addr_ff  <= nxt_addr;
            dout_ff  <= nxt_dout;  rdata_ff <= nxt_rdata; rd_ff  <= nxt_rd;
            step_ff  <= nxt_step;  poll_ff <= nxt_poll; pcnt_ff  <= nxt_pcnt;
            busy_ff  <= nxt_busy;  done_ff <= nxt_done; err_ff   <= nxt_err;
        end
    end

    assign o_busy = busy_ff;            assign o_done = done_ff;
    assign o_error = err_ff;            assign o_rdata = rdata_ff;
    assign o_mode = mode_ff;            assign o_ce_n = ce_n_ff;
    assign o_oe_n = oe_n_ff;            assign o_we_n = we_n_ff;
    assign o_hard_reset_n = rst_n_ff;   assign o_address_lines = addr_ff;
    assign o_data_lines_out = dout_ff;  assign o_data_lines_oe = doe_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    write_pin_state_a: assert property (!we_n_ff |-> oe_n_ff && !ce_n_ff)
        else $error("write strobe low without select or with drive low");
    read_pin_state_a: assert property (!oe_n_ff |-> we_n_ff && !ce_n_ff)
        else $error("output drive low without select or with strobe low");
    reset_quiet_a: assert property (!rst_n_ff |-> ce_n_ff && oe_n_ff && we_n_ff && !doe_ff)
        else $error("bus active during hard reset");
    no_contention_a: assert property (doe_ff |-> oe_n_ff)
        else $error("host drives data while output drive low");
    strobe_width_a: assert property ($fell(we_n_ff) |-> !we_n_ff [*6])
        else $error("write strobe pulse too short");
    strobe_first_a: assert property ($rose(we_n_ff) |-> !ce_n_ff && doe_ff && $stable(dout_ff))
        else $error("write strobe did not rise first with data held");
    reset_to_array_a: assert property ($rose(rst_n_ff) |-> ##[1:20] mode_ff == MD_ARRAY)
        else $error("mode not array after reset release");
    erase_confirm_a: assert property ($fell(we_n_ff) && step_ff && req_ff.op == OP_ERASE
            |-> dout_ff == CMD_ERASE_CONFIRM)
        else $error("erase second write not confirm code");
    poll_reads_only_a: assert property (poll_ff && !we_n_ff |-> 1'b0)
        else $error("write issued while polling");

    erase_cov: cover property (done_ff && req_ff.op == OP_ERASE);
    program_cov: cover property (done_ff && req_ff.op == OP_PROGRAM);
    abort_cov: cover property ($fell(rst_n_ff) && poll_ff);
    read_cov: cover property (done_ff && req_ff.op == OP_READ);

endmodule : flash_bus_host

// >>> tb/flash_dev_model.sv
// ----------------------------------------------------------------------
// Behavioural flash device on the far side of the host pins
// ----------------------------------------------------------------------
// Assumes the data wire is resolved by the bench from both drivers.
`timescale 1ns/1ps
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0]        PROT_BLK = 8'h3f,
    parameter logic [DATA_W-1:0] SIG_CODE = 16'h00a5, // Arbitrary value
    parameter logic [DATA_W-1:0] CFI_WORD = 16'h0051
) (
    input  wire logic              i_slow,
    input  wire logic              i_ce_n,
    input  wire logic              i_oe_n,
    input  wire logic              i_we_n,
    input  wire logic              i_hard_reset_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0]      o_dq
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] sr = 16'h0080, rd, last_q = 16'h0000;
    logic [ADDR_W-1:0] busy_a = '0;
    logic              drv;
    int                mode = 0, pend = 0, busy = 0;
    realtime           we_fall = 0.0;
    // Read source follows the last command; a running job forces status
    always @* begin
        if (busy > 0 || mode == 1) rd = sr;
        else if (mode == 2) rd = SIG_CODE;
        else if (mode == 3) rd = CFI_WORD;
        else rd = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
    end
    // Released wire shows the inverse of the last word, never a stale copy
    // Automatic standby never cuts a read short, so drive follows the pins
    assign drv  = !i_ce_n && !i_oe_n && i_hard_reset_n;
    assign o_dq = drv ? rd : ~last_q;
    always @(negedge drv) last_q = rd;
    // Command interpreter, one call per captured bus write
    task automatic take(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        if (busy > 0) begin
            if (d == 16'h0070) mode = 1;
        end else if (pend == 1) begin
            pend = 0;
            mode = 1;
            if (d != CMD_ERASE_CONFIRM) sr[5:4] = 2'b11;
            else if (a[19:12] == PROT_BLK) sr[5] = 1'b1;
            else begin
                foreach (mem[k]) if (k[19:12] == a[19:12]) mem[k] = 16'hffff;
                busy   = i_slow ? 2000 : 30;
                busy_a = a;
                sr[7]  = 1'b0;
            end
        end else if (pend == 2) begin
            pend   = 0;
            mode   = 1;
            mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & d;
            busy   = i_slow ? 2000 : 30;
            busy_a = a;
            sr[7]  = 1'b0;
        end else begin
            case (d)
                CMD_READ_ARRAY: mode = 0;
                16'h0070:       mode = 1;
                16'h0090:       mode = 2;
                16'h0098:       mode = 3;
                16'h0020:       pend = 1;
                16'h0040:       pend = 2;
                default:        mode = 0;
            endcase
        end
    endtask : take
    // Address and data latch on the strobe's rising edge; short pulses are glitches
    always @(negedge i_we_n) we_fall = $realtime;
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_oe_n && i_hard_reset_n && ($realtime - we_fall) >= 5.0) begin
            take(i_addr, i_dq);
        end
    end
    // Job timer in 10 ns steps
    always #10 if (busy > 0) begin
        busy = busy - 1;
        if (busy == 0) sr[7] = 1'b1;
    end
    // Hard reset aborts a job and leaves its word corrupt
    always @(negedge i_hard_reset_n) begin
        if (busy > 0) mem[busy_a] = 16'h0000;
        busy = 0;
        pend = 0;
        mode = 0;
        sr   = 16'h0080;
    end
endmodule : flash_dev_model

// >>> tb/flash_bus_command_interface_tb_top.sv
// ----------------------------------------------------------------------
// Self-checking bench for the flash bus host controller
// ----------------------------------------------------------------------
// Assumes the device model answers on the resolved data wire.
`timescale 1ns/1ps
module flash_bus_command_interface_tb_top;
    import flash_host_pkg::*;
    logic              i_clk_sys = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0, slow = 1'b0;
    req_type           i_req = '0;
    logic              o_busy, o_done, o_error, o_ce_n, o_oe_n, o_we_n, o_hard_reset_n;
    logic              o_data_lines_oe;
    logic [DATA_W-1:0] o_rdata, o_data_lines_out, dev_dq;
    logic [ADDR_W-1:0] o_address_lines;
    mode_type          o_mode;
    wire  [DATA_W-1:0] dq_wire;
    int                failures = 0, checks_done = 0;
    // Bench clock and wire resolution
    always #5 i_clk_sys = ~i_clk_sys;
    assign dq_wire = o_data_lines_oe ? o_data_lines_out : dev_dq;
    flash_bus_host #(.POLL_LIMIT(4)) DUT (
        .i_clk_sys, .i_rst, .i_req_valid, .i_req, .o_busy, .o_done, .o_error, .o_rdata,
        .o_mode, .o_ce_n, .o_oe_n, .o_we_n, .o_hard_reset_n, .o_address_lines,
        .o_data_lines_out, .o_data_lines_oe, .i_data_lines_in(dq_wire));
    flash_dev_model dev (
        .i_slow(slow), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_hard_reset_n(o_hard_reset_n), .i_addr(o_address_lines), .i_dq(dq_wire),
        .o_dq(dev_dq));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One request, then a bounded wait for the done pulse
    task automatic run(input op_type op, input logic [19:0] a, input logic [15:0] d);
        int n;
        @(posedge i_clk_sys);
        #1;
        i_req_valid = 1'b1;
        i_req = '{op: op, addr: a, data: d};
        @(posedge i_clk_sys);
        #1;
        i_req_valid = 1'b0;
        chk("busy after take", 16'h0001, 16'(o_busy));
        for (n = 0; n < 3000; n++) begin
            if (o_done === 1'b1) break;
            @(posedge i_clk_sys);
            #1;
        end
        if (n == 3000) begin
            failures++;
            $display("[ERR] done wait expected 1 seen 0");
            results();
        end
        chk("busy at done", 16'h0000, 16'(o_busy));
    endtask : run
    // Pin discipline watched every cycle, away from the launching edge
    always @(negedge i_clk_sys) if (!i_rst) begin
        chk("drive during read", 16'h0000, 16'(!o_oe_n && o_data_lines_oe));
        chk("pins in reset", 16'h0000, 16'(!o_hard_reset_n && !(o_ce_n && o_oe_n && o_we_n)));
        chk("write with drive low", 16'h0000, 16'(!o_we_n && !o_oe_n));
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [19:0] a, p;
        logic [15:0] w [3];
        op_type      cmds [3]  = '{OP_STATUS_CMD, OP_SIG_CMD, OP_CFI_CMD};
        mode_type    modes [3] = '{MD_STATUS, MD_SIG, MD_CFI};
        logic [15:0] reads [3] = '{16'h0080, 16'h00a5, 16'h0051};
        void'($urandom(32'h2954aec7));
        repeat (4) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        chk("mode after reset", 16'(MD_ARRAY), 16'(o_mode));
        a = {8'h05, 10'($urandom), 2'b00}; // Keeps a+0..a+2 inside one block
        p = {8'h3f, 12'($urandom)};
        run(OP_READ, a, 16'h0000);
        chk("erased word", 16'hffff, o_rdata);
        $display("test erased read done");
        // Back-to-back programs, reference words kept in the bench
        for (int k = 0; k < 3; k++) begin
            w[k] = 16'($urandom);
            run(OP_PROGRAM, a + 20'(k), w[k]);
            chk("program status", 16'h0080, o_rdata);
            chk("program mode", 16'(MD_STATUS), 16'(o_mode));
        end
        run(OP_ARRAY_CMD, 20'h00000, CMD_READ_ARRAY);
        for (int k = 0; k < 3; k++) begin
            run(OP_READ, a + 20'(k), 16'h0000);
            chk("programmed word", w[k], o_rdata);
        end
        $display("test program done");
        // Status, signature and CFI mode commands, each followed by a read elsewhere
        for (int k = 0; k < 3; k++) begin
            run(cmds[k], 20'h00000, 16'h0000);
            chk("mode", 16'(modes[k]), 16'(o_mode));
            run(OP_READ, 20'($urandom), 16'h0000);
            chk("mode read", reads[k], o_rdata);
        end
        $display("test read modes done");
        // Block erase, then erase of a protected block
        run(OP_ERASE, a, CMD_ERASE_CONFIRM);
        chk("erase error", 16'h0000, 16'(o_error));
        run(OP_ARRAY_CMD, 20'h00000, CMD_READ_ARRAY);
        run(OP_READ, a + 20'h00001, 16'h0000);
        chk("erased block", 16'hffff, o_rdata);
        run(OP_PROGRAM, p, w[0]);
        run(OP_ERASE, p, CMD_ERASE_CONFIRM);
        chk("protected erase", 16'h0001, 16'(o_error));
        run(OP_ARRAY_CMD, 20'h00000, CMD_READ_ARRAY);
        run(OP_READ, p, 16'h0000);
        chk("protected data", w[0], o_rdata);
        $display("test erase done");
        // Slow device: poll limit aborts with hard reset
        slow = 1'b1;
        run(OP_PROGRAM, a, w[1]);
        slow = 1'b0;
        chk("abort error", 16'h0001, 16'(o_error));
        chk("abort mode", 16'(MD_ARRAY), 16'(o_mode));
        run(OP_ERASE, a, CMD_ERASE_CONFIRM);
        run(OP_ARRAY_CMD, 20'h00000, CMD_READ_ARRAY);
        run(OP_READ, a, 16'h0000);
        chk("re-erased word", 16'hffff, o_rdata);
        $display("test abort done");
        // Hard reset request returns the tracked mode to array
        run(OP_STATUS_CMD, 20'h00000, 16'h0000);
        run(OP_RESET, 20'h00000, 16'h0000);
        chk("reset op mode", 16'(MD_ARRAY), 16'(o_mode));
        chk("reset op error", 16'h0000, 16'(o_error));
        run(OP_READ, a, 16'h0000);
        chk("read after reset", 16'hffff, o_rdata);
        $display("test reset op done");
        results();
    end
endmodule : flash_bus_command_interface_tb_top
